// ### src/mdcs_pkg.sv
// Constants shared by the motor driver control/status register block
package mdcs_pkg;
  localparam int DATA_W = 8;
  localparam int SPEED_W = 9;
  localparam int BIT_CNT_W = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Register offsets
  localparam logic [7:0] OFF_SPEED_LO = 8'h00;
  localparam logic [7:0] OFF_SPEED_HI = 8'h01;
  localparam logic [7:0] OFF_PROG_KEY = 8'h02;
  localparam logic [7:0] OFF_NVM_CTRL = 8'h03;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CFG_FIRST = 8'h20;
  localparam logic [7:0] OFF_CFG_LAST = 8'h2B;

  // Field positions
  localparam int BIT_HOST_SPEED_A = 7;
  localparam int BIT_SPEED_MSB = 0;
  localparam int BIT_LP_INHIBIT = 7;
  localparam int BIT_CFG_WEN = 6;
  localparam int BIT_RELOAD = 5;
  localparam int BIT_PROGRAM = 4;
  localparam int BIT_THERMAL = 7;
  localparam int BIT_LOW_POWER = 6;
  localparam int BIT_OVERCURRENT = 5;
  localparam int BIT_LOCKED = 4;

  // Values
  localparam logic [7:0] PROGRAM_KEY_VALUE = 8'hB6;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [8:0] SPEED_RESET = 9'h000;
  // Arbitrary neutral serial address
  localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h2A;

  // Index of each status input and serial pin in its synchroniser bundle
  localparam int SYN_THERMAL = 0;
  localparam int SYN_LOW_POWER = 1;
  localparam int SYN_OVERCURRENT = 2;
  localparam int SYN_LOCKED = 3;
  localparam int SYN_STATUS_W = 4;
  localparam int SYN_SCL = 0;
  localparam int SYN_SDA = 1;
  localparam int SYN_PIN_W = 2;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_DATA_WR,
    ST_WR_ACK,
    ST_DATA_RD,
    ST_RD_ACK
  } mdcs_state_type;
endpackage

// ### src/mdcs_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module mdcs_sync #(
  parameter int W = 1
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_sys_rst, // Synchronous reset, active high
  input wire logic [W-1:0] i_async, // Levels from outside the domain
  output logic [W-1:0] o_sync // Synchronised levels
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// ### src/mdcs_sticky.sv
// Sticky flag: set by hardware, cleared by a read, set wins
`timescale 1ns/1ps
module mdcs_sticky (
  input wire logic i_clk_sys, // System clock
  input wire logic i_sys_rst, // Synchronous reset, active high
  input wire logic i_set, // Event level or pulse
  input wire logic i_clr, // Clear pulse
  output logic o_flag // Latched flag
);
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clr) begin
      o_flag <= 1'b0;
    end
  end
endmodule

// ### src/mdcs_regs.sv
// Motor driver control/status registers behind a two-wire serial slave
`timescale 1ns/1ps
// Functional notes
// - Speed command is nine bits; low eight live in offset 0x00.
// - Serial speed writes are accepted only while the host_speed_a bit is one.
// - Speed command MSB sits in bit 0 of offset 0x01.
// - Pending MSB is captured on the high-byte write; all nine bits update together on the low-byte write.
// - Programming needs key 0xB6 at 0x02, then immediately the program trigger.
// - Stored key clears on the next write to any offset other than 0x02, the trigger write included.
// - Low-power inhibit bit (0x03 bit 7) blocks sleep or standby.
// - Configuration writes pass only while config write enable is one.
// - Reload bit copies nonvolatile contents into configuration registers.
// - Program trigger bit (0x03 bit 4) starts nonvolatile programming.
// - Status bit 7 reports over-temperature.
// - Status bit 6 shows sleep or standby entered.
// - Overcurrent event latches into status bit 5 and stays set.
// - Reading the status register clears the overcurrent latch.
// - Status bit 4 shows a locked motor.
module mdcs_regs
  import mdcs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEFAULT_DEV_ADDR
) (
  input wire logic i_clk_sys, // 20 MHz system clock
  input wire logic i_sys_rst, // Synchronous reset, active high
  input wire logic i_scl, // Serial clock pin
  input wire logic i_sda, // Serial data pin level
  output logic o_sda_out, // Serial data drive value
  output logic o_sda_oe, // Serial data drive enable
  input wire logic i_thermal_flag, // Over-temperature level
  input wire logic i_low_power_active, // Sleep or standby entered
  input wire logic i_overcurrent, // Phase overcurrent level
  input wire logic i_rotor_locked, // Motor lock detected
  output logic [SPEED_W-1:0] o_speed_command, // Applied speed command
  output logic o_host_speed_a, // Host speed host_speed_a
  output logic o_low_power_inhibit, // Block sleep or standby
  output logic o_cfg_write_en, // Config write enable
  output logic o_nvm_reload, // Reload pulse
  output logic o_nvm_program_trigger, // Program pulse
  output logic o_cfg_wr_stb, // Config write pulse
  output logic [DATA_W-1:0] o_cfg_addr, // Config write offset
  output logic [DATA_W-1:0] o_cfg_data // Config write data
);
  logic [SYN_PIN_W-1:0] pin_sync;
  logic [SYN_STATUS_W-1:0] stat_sync;
  logic scl_prev_q, sda_prev_q;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  mdcs_state_type state_q;
  logic [BIT_CNT_W-1:0] bit_cnt_q;
  logic [DATA_W-1:0] shift_q;
  logic [DATA_W-1:0] tx_q;
  logic [DATA_W-1:0] ptr_q;
  logic rw_q, nack_q;
  logic wr_now, rd_load;
  logic [DATA_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] status_byte;
  logic overcurrent_latch;
  logic speed_msb_pending_q;
  logic [DATA_W-1:0] nvm_program_key_q;

  mdcs_sync #(.W(SYN_PIN_W)) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(1'b0), // Free-running: keeps the idle-high pin level, no false edge after reset
    .i_async({i_sda, i_scl}),
    .o_sync(pin_sync)
  );

  mdcs_sync #(.W(SYN_STATUS_W)) u_stat_sync (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async({i_rotor_locked, i_overcurrent, i_low_power_active, i_thermal_flag}),
    .o_sync(stat_sync)
  );

  // Level input: the latch keeps setting while overcurrent persists
  mdcs_sticky u_oc_latch (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_set(stat_sync[SYN_OVERCURRENT]),
    .i_clr(rd_load && (rd_addr == OFF_STATUS)),
    .o_flag(overcurrent_latch)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= pin_sync[SYN_SCL];
      sda_prev_q <= pin_sync[SYN_SDA];
    end
  end

  assign scl_rise = pin_sync[SYN_SCL] && !scl_prev_q;
  assign scl_fall = !pin_sync[SYN_SCL] && scl_prev_q;
  assign start_cond = pin_sync[SYN_SCL] && scl_prev_q && sda_prev_q && !pin_sync[SYN_SDA];
  assign stop_cond = pin_sync[SYN_SCL] && scl_prev_q && !sda_prev_q && pin_sync[SYN_SDA];

  assign wr_now = scl_fall && (state_q == ST_DATA_WR) && (bit_cnt_q == BITS_PER_BYTE);
  assign rd_load = scl_fall && (((state_q == ST_ADDR_ACK) && rw_q) ||
                                ((state_q == ST_RD_ACK) && !nack_q));
  assign rd_addr = (state_q == ST_ADDR_ACK) ? ptr_q : ptr_q + 8'h01;

  always_comb begin
    status_byte = BYTE_ZERO;
    status_byte[BIT_THERMAL] = stat_sync[SYN_THERMAL];
    status_byte[BIT_LOW_POWER] = stat_sync[SYN_LOW_POWER];
    status_byte[BIT_OVERCURRENT] = overcurrent_latch;
    status_byte[BIT_LOCKED] = stat_sync[SYN_LOCKED];
  end

  // Trigger bits are self-clearing, so they read back as zero
  always_comb begin
    rd_data = BYTE_ZERO;
    if (rd_addr == OFF_SPEED_LO) begin
      rd_data = o_speed_command[DATA_W-1:0];
    end else if (rd_addr == OFF_SPEED_HI) begin
      rd_data[BIT_HOST_SPEED_A] = o_host_speed_a;
      rd_data[BIT_SPEED_MSB] = speed_msb_pending_q;
    end else if (rd_addr == OFF_PROG_KEY) begin
      rd_data = nvm_program_key_q;
    end else if (rd_addr == OFF_NVM_CTRL) begin
      rd_data[BIT_LP_INHIBIT] = o_low_power_inhibit;
      rd_data[BIT_CFG_WEN] = o_cfg_write_en;
    end else if (rd_addr == OFF_STATUS) begin
      rd_data = status_byte;
    end
  end

  // Serial slave sequencing; start and stop win over any bit activity
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= '0;
      shift_q <= BYTE_ZERO;
      tx_q <= BYTE_ZERO;
      ptr_q <= BYTE_ZERO;
      rw_q <= 1'b0;
      nack_q <= 1'b1;
      o_sda_oe <= 1'b0;
    end else if (start_cond) begin
      state_q <= ST_ADDR;
      bit_cnt_q <= '0;
      o_sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state_q <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (state_q == ST_RD_ACK) begin
        nack_q <= pin_sync[SYN_SDA];
      end else if (state_q == ST_ADDR || state_q == ST_PTR || state_q == ST_DATA_WR ||
                   state_q == ST_DATA_RD) begin
        shift_q <= {shift_q[DATA_W-2:0], pin_sync[SYN_SDA]};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: begin
          if (bit_cnt_q == BITS_PER_BYTE) begin
            if (shift_q[DATA_W-1:1] == DEV_ADDR) begin
              rw_q <= shift_q[0];
              o_sda_oe <= 1'b1;
              state_q <= ST_ADDR_ACK;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          bit_cnt_q <= '0;
          if (rw_q) begin
            tx_q <= rd_data;
            o_sda_oe <= !rd_data[DATA_W-1];
            state_q <= ST_DATA_RD;
          end else begin
            o_sda_oe <= 1'b0;
            state_q <= ST_PTR;
          end
        end
        ST_PTR: begin
          if (bit_cnt_q == BITS_PER_BYTE) begin
            ptr_q <= shift_q;
            o_sda_oe <= 1'b1;
            state_q <= ST_PTR_ACK;
          end
        end
        ST_PTR_ACK, ST_WR_ACK: begin
          bit_cnt_q <= '0;
          o_sda_oe <= 1'b0;
          state_q <= ST_DATA_WR;
        end
        ST_DATA_WR: begin
          if (bit_cnt_q == BITS_PER_BYTE) begin
            ptr_q <= ptr_q + 8'h01;
            o_sda_oe <= 1'b1;
            state_q <= ST_WR_ACK;
          end
        end
        ST_DATA_RD: begin
          if (bit_cnt_q == BITS_PER_BYTE) begin
            o_sda_oe <= 1'b0;
            state_q <= ST_RD_ACK;
          end else begin
            tx_q <= {tx_q[DATA_W-2:0], 1'b0};
            o_sda_oe <= !tx_q[DATA_W-2];
          end
        end
        ST_RD_ACK: begin
          bit_cnt_q <= '0;
          if (nack_q) begin
            state_q <= ST_IDLE;
          end else begin
            ptr_q <= rd_addr;
            tx_q <= rd_data;
            o_sda_oe <= !rd_data[DATA_W-1];
            state_q <= ST_DATA_RD;
          end
        end
        default: begin
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain: only ever pulls low
  always_ff @(posedge i_clk_sys) begin
    o_sda_out <= 1'b0;
  end

  // Speed command
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_host_speed_a <= 1'b0;
      speed_msb_pending_q <= 1'b0;
      o_speed_command <= SPEED_RESET;
    end else if (wr_now && ptr_q == OFF_SPEED_HI) begin
      o_host_speed_a <= shift_q[BIT_HOST_SPEED_A];
      if (shift_q[BIT_HOST_SPEED_A]) begin
        speed_msb_pending_q <= shift_q[BIT_SPEED_MSB];
      end
    end else if (wr_now && ptr_q == OFF_SPEED_LO && o_host_speed_a) begin
      o_speed_command <= {speed_msb_pending_q, shift_q};
    end
  end

  // Any write other than the key itself discards the key
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      nvm_program_key_q <= BYTE_ZERO;
    end else if (wr_now) begin
      nvm_program_key_q <= (ptr_q == OFF_PROG_KEY) ? shift_q : BYTE_ZERO;
    end
  end

  // Control bits and one-cycle trigger pulses
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_low_power_inhibit <= 1'b0;
      o_cfg_write_en <= 1'b0;
      o_nvm_reload <= 1'b0;
      o_nvm_program_trigger <= 1'b0;
    end else if (wr_now && ptr_q == OFF_NVM_CTRL) begin
      o_low_power_inhibit <= shift_q[BIT_LP_INHIBIT];
      o_cfg_write_en <= shift_q[BIT_CFG_WEN];
      o_nvm_reload <= shift_q[BIT_RELOAD];
      o_nvm_program_trigger <= shift_q[BIT_PROGRAM] &&
                               (nvm_program_key_q == PROGRAM_KEY_VALUE);
    end else begin
      o_nvm_reload <= 1'b0;
      o_nvm_program_trigger <= 1'b0;
    end
  end

  // Configuration write forwarding
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_cfg_wr_stb <= 1'b0;
      o_cfg_addr <= BYTE_ZERO;
      o_cfg_data <= BYTE_ZERO;
    end else begin
      o_cfg_wr_stb <= wr_now && o_cfg_write_en && (ptr_q >= OFF_CFG_FIRST) &&
                      (ptr_q <= OFF_CFG_LAST);
      if (wr_now) begin
        o_cfg_addr <= ptr_q;
        o_cfg_data <= shift_q;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  AST_SPEED_LOAD: assert property (
    wr_now && ptr_q == OFF_SPEED_LO && o_host_speed_a |=>
      o_speed_command == {$past(speed_msb_pending_q), $past(shift_q)})
    else $error("speed command not loaded as nine bits");
  AST_SPEED_GATED: assert property (
    !(wr_now && ptr_q == OFF_SPEED_LO && o_host_speed_a) |=> $stable(o_speed_command))
    else $error("speed command changed without an accepted low write");
  AST_PROGRAM_SEQ: assert property (
    wr_now && ptr_q == OFF_NVM_CTRL && shift_q[BIT_PROGRAM] &&
      nvm_program_key_q == PROGRAM_KEY_VALUE |=> o_nvm_program_trigger ##1 !o_nvm_program_trigger)
    else $error("program pulse missing after key sequence");
  AST_PROGRAM_ONLY: assert property (
    o_nvm_program_trigger |-> $past(nvm_program_key_q) == PROGRAM_KEY_VALUE && $past(wr_now))
    else $error("program pulse without key");
  AST_KEY_CLEAR: assert property (
    wr_now && ptr_q != OFF_PROG_KEY |=> nvm_program_key_q == BYTE_ZERO)
    else $error("key survived another write");
  AST_INHIBIT: assert property (
    wr_now && ptr_q == OFF_NVM_CTRL |=> o_low_power_inhibit == $past(shift_q[BIT_LP_INHIBIT]))
    else $error("inhibit bit not taken");
  AST_CFG_GATE: assert property (
    o_cfg_wr_stb |-> $past(o_cfg_write_en))
    else $error("config write while disabled");
  AST_RELOAD: assert property (
    wr_now && ptr_q == OFF_NVM_CTRL && shift_q[BIT_RELOAD] |=> o_nvm_reload)
    else $error("reload pulse missing");
  AST_STATUS_PINS: assert property (
    status_byte[BIT_THERMAL] == $past(i_thermal_flag, 2) &&
      status_byte[BIT_LOCKED] == $past(i_rotor_locked, 2) &&
      status_byte[BIT_LOW_POWER] == $past(i_low_power_active, 2))
    else $error("status bits do not follow inputs");
  AST_OC_STICKY: assert property (
    $fell(stat_sync[SYN_OVERCURRENT]) && !$past(rd_load && rd_addr == OFF_STATUS) |->
      overcurrent_latch)
    else $error("overcurrent latch lost");
  AST_OC_CLEAR: assert property (
    rd_load && rd_addr == OFF_STATUS && !stat_sync[SYN_OVERCURRENT] |=> !overcurrent_latch)
    else $error("status read did not clear overcurrent");
  AST_UNUSED_ZERO: assert property (
    status_byte[BIT_LOCKED-1:0] == 4'h0 && !(rd_addr == OFF_SPEED_HI && |rd_data[6:1]))
    else $error("unused bits read nonzero");
endmodule

// ### tb/mdcs_host_model.sv
// Serial bus host model that reaches the register block
`timescale 1ns/1ps
module mdcs_host_model
  import mdcs_pkg::*;
#(
  parameter logic [6:0] ADDR = DEFAULT_DEV_ADDR
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_sda, // Resolved data line level
  output logic o_scl, // Serial clock, idles high
  output logic o_sda_low // Pull data line low
);
  logic last_ack; // Address acknowledge, 0 = taken
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    last_ack = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // Five cycles a phase, so every level outlives the two-flop sampling
  task automatic clk_bit(input logic low, output logic smp);
    o_sda_low <= low;
    hold(5);
    o_scl <= 1'b1;
    hold(3);
    smp = i_sda;
    hold(2);
    o_scl <= 1'b0;
    hold(5);
  endtask
  // Also serves as repeated start: data is released before clock rises
  task automatic start();
    o_sda_low <= 1'b0;
    hold(5);
    o_scl <= 1'b1;
    hold(5);
    o_sda_low <= 1'b1;
    hold(5);
    o_scl <= 1'b0;
    hold(5);
  endtask
  task automatic stop();
    o_sda_low <= 1'b1;
    hold(5);
    o_scl <= 1'b1;
    hold(5);
    o_sda_low <= 1'b0;
    hold(5);
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(~b[i], d);
    end
    clk_bit(1'b0, ack);
  endtask
  task automatic recv(output logic [7:0] b);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, b[i]);
    end
    // Host answers NACK to end the read
    clk_bit(1'b0, d);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    logic k;
    start();
    send({a, 1'b0}, last_ack);
    if (last_ack === 1'b0) begin
      send(p, k);
      send(d, k);
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic k;
    start();
    send({ADDR, 1'b0}, last_ack);
    send(p, k);
    start();
    send({ADDR, 1'b1}, k);
    recv(d);
    stop();
  endtask
endmodule

// ### tb/mdcs_regs_tb.sv
// Self-checking bench for the motor driver register block
`timescale 1ns/1ps
module mdcs_regs_tb;
  import mdcs_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] stat_in = 4'h0; // thermal, low power, overcurrent, locked
  logic scl, sda_low, sda_wire, sda_out, sda_oe;
  logic [8:0] speed;
  logic ovr, lpi, cfg_en, reload, prog, cfg_stb;
  logic [7:0] cfg_addr, cfg_data;
  logic [15:0] last_cfg = 16'h0000;
  int n_reload = 0;
  int n_prog = 0;
  int n_stb = 0;
  int n_errors = 0;
  int compares = 0;

  always #25 i_clk_sys = ~i_clk_sys;
  assign sda_wire = (sda_oe === 1'b1 || sda_low === 1'b1) ? 1'b0 : 1'b1;

  mdcs_regs #(.DEV_ADDR(DEFAULT_DEV_ADDR)) mdcs_regs_inst (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda_wire),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_thermal_flag(stat_in[3]),
    .i_low_power_active(stat_in[2]), .i_overcurrent(stat_in[1]),
    .i_rotor_locked(stat_in[0]), .o_speed_command(speed), .o_host_speed_a(ovr),
    .o_low_power_inhibit(lpi), .o_cfg_write_en(cfg_en), .o_nvm_reload(reload),
    .o_nvm_program_trigger(prog), .o_cfg_wr_stb(cfg_stb), .o_cfg_addr(cfg_addr),
    .o_cfg_data(cfg_data));

  mdcs_host_model #(.ADDR(DEFAULT_DEV_ADDR)) mdcs_host_model_inst (
    .i_clk_sys(i_clk_sys), .i_sda(sda_wire), .o_scl(scl), .o_sda_low(sda_low));

  // Pulses last one cycle, so count them where they stand
  always @(posedge i_clk_sys) begin
    if (reload === 1'b1) n_reload++;
    if (prog === 1'b1) n_prog++;
    if (cfg_stb === 1'b1) begin
      n_stb++;
      last_cfg = {cfg_addr, cfg_data};
    end
  end

  task automatic test_done();
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: port %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    mdcs_host_model_inst.wr(DEFAULT_DEV_ADDR, p, d);
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    mdcs_host_model_inst.rd(p, d);
    chk_byte(d, e);
  endtask

  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    repeat (5) @(posedge i_clk_sys);
    chk_out({6'h00, sda_out, speed}, 16'h0000);
    rd_chk(OFF_SPEED_HI, 8'h00);
    rd_chk(8'h05, 8'h00);
    wr(OFF_SPEED_LO, 8'h55);
    chk_out(16'(speed), 16'h0000);
    wr(OFF_SPEED_HI, 8'hFF);
    chk_out(16'(ovr), 16'h0001);
    chk_out(16'(speed), 16'h0000);
    rd_chk(OFF_SPEED_HI, 8'h81);
    wr(OFF_SPEED_LO, 8'h34);
    chk_out(16'(speed), 16'h0134);
    rd_chk(OFF_SPEED_LO, 8'h34);
    wr(OFF_SPEED_HI, 8'h80);
    wr(OFF_SPEED_LO, 8'hC3);
    chk_out(16'(speed), 16'h00C3);
    wr(OFF_SPEED_HI, 8'h01);
    wr(OFF_SPEED_LO, 8'h77);
    chk_out(16'(speed), 16'h00C3);
    chk_out(16'(ovr), 16'h0000);
    wr(OFF_NVM_CTRL, 8'hFF);
    chk_out(16'({lpi, cfg_en}), 16'h0003);
    chk_out(16'(n_reload), 16'h0001);
    chk_out(16'(n_prog), 16'h0000);
    rd_chk(OFF_NVM_CTRL, 8'hC0);
    wr(OFF_CFG_FIRST, 8'h5A);
    chk_out(16'(n_stb), 16'h0001);
    chk_out(last_cfg, 16'h205A);
    wr(OFF_NVM_CTRL, 8'h00);
    wr(8'h21, 8'h11);
    chk_out(16'(n_stb), 16'h0001);
    chk_out(16'({lpi, cfg_en}), 16'h0000);
    wr(OFF_PROG_KEY, PROGRAM_KEY_VALUE);
    wr(OFF_NVM_CTRL, 8'h10);
    chk_out(16'(n_prog), 16'h0001);
    rd_chk(OFF_PROG_KEY, 8'h00);
    wr(OFF_PROG_KEY, PROGRAM_KEY_VALUE);
    wr(8'h05, 8'h00);
    wr(OFF_NVM_CTRL, 8'h10);
    chk_out(16'(n_prog), 16'h0001);
    wr(OFF_PROG_KEY, 8'hB7);
    wr(OFF_NVM_CTRL, 8'h10);
    chk_out(16'(n_prog), 16'h0001);
    // One level at a time so a swapped bit shows
    for (int i = 0; i < 4; i++) begin
      if (i != 1) begin
        stat_in <= 4'(1 << i);
        repeat (4) @(posedge i_clk_sys);
        rd_chk(OFF_STATUS, 8'(16 << i));
      end
    end
    stat_in <= 4'h2;
    repeat (4) @(posedge i_clk_sys);
    stat_in <= 4'h0;
    repeat (4) @(posedge i_clk_sys);
    rd_chk(OFF_STATUS, 8'h20);
    rd_chk(OFF_STATUS, 8'h00);
    wr(OFF_STATUS, 8'hFF);
    rd_chk(OFF_STATUS, 8'h00);
    test_done();
  end

  initial begin
    repeat (40000) @(posedge i_clk_sys);
    n_errors++;
    test_done();
  end
endmodule
